/* File: hw/prc_pkg.sv */
package prc_pkg;
  // link widths
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int CFG_DEPTH = 128;
  localparam logic [15:0] CFG_WORD_RST = 16'h0000;

  // clock period, in ps
  localparam int CLK_PERIOD_PS = 5000;

  // reset sequence time after lock, in ns, rounded up to whole cycles
  localparam int RST_SEQ_NS = 100;
  localparam int RST_SEQ_CYC = (RST_SEQ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // clock edges from the sampled strobe to the ready acknowledge
  localparam int ACK_LAT_CYC = 2;

  // ref_clk cycles per half period of the shared phy clock
  localparam int PHY_DIV_CYC = 2;

  // interfaces joined in a multi-interface design
  localparam int N_INTF = 2;

  typedef enum logic [1:0] {
    PRC_RS_WAIT_LOCK = 2'h0,
    PRC_RS_COUNT = 2'h1,
    PRC_RS_DONE = 2'h3
  } prc_rs_e;

  typedef enum logic {
    PRC_XS_IDLE = 1'h0,
    PRC_XS_BUSY = 1'h1
  } prc_xs_e;

  typedef enum logic {
    PRC_HS_IDLE = 1'h0,
    PRC_HS_WAIT = 1'h1
  } prc_hs_e;
endpackage

/* File: hw/prc_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface prc_if;
  // transaction request, fabric logic to device
  logic [prc_pkg::ADDR_W-1:0] cfg_addr;
  logic cfg_strobe;
  logic cfg_write_sel;
  logic [prc_pkg::DATA_W-1:0] reconfig_write_word;
  // transaction answer, device to fabric logic
  logic [prc_pkg::DATA_W-1:0] cfg_read_word;
  logic cfg_ack;
  // multi-interface support
  logic rst_seq_done;
  logic intf_rdy;
  logic multi_intf_lock_in;
  logic shared_second_phy_clock_out;

  modport dev (
    input cfg_addr,
    input cfg_strobe,
    input cfg_write_sel,
    input reconfig_write_word,
    input multi_intf_lock_in,
    output cfg_read_word,
    output cfg_ack,
    output rst_seq_done,
    output intf_rdy,
    output shared_second_phy_clock_out
  );

  modport host (
    output cfg_addr,
    output cfg_strobe,
    output cfg_write_sel,
    output reconfig_write_word,
    output multi_intf_lock_in,
    input cfg_read_word,
    input cfg_ack,
    input rst_seq_done,
    input intf_rdy,
    input shared_second_phy_clock_out
  );
endinterface // prc_if
`default_nettype wire

/* File: hw/prc_device_end.sv */
// Function
// [R1] 7-bit address matters only with strobe
// [R2] fabric starts each transaction with strobe
// [R3] write-select high writes, low reads
// [R4] write word captured in strobe cycle
// [R5] acknowledge ends transaction; read word valid then
// [R6] interface-ready rises after reset sequence completes
// [R7] combined lock is AND of all locks
// [R8] fabric-side ports run on application clock
// [R9] master drives second phy clock on shared output
// [R10] reset-sequence-done gates fabric transactions
// [R11] strobe one cycle; wait for acknowledge
// [R12] acknowledge is one cycle per transaction
`timescale 1ns/1ps
`default_nettype none
module prc_device_end #(
  parameter bit MULTI_INTF_EN = 1'b1,
  parameter bit IS_MASTER = 1'b1,
  parameter int unsigned RST_SEQ_CYCLES = prc_pkg::RST_SEQ_CYC,
  parameter int unsigned ACK_LAT = prc_pkg::ACK_LAT_CYC,
  parameter int unsigned PHY_DIV = prc_pkg::PHY_DIV_CYC
) (
  // clock and reset; ref_clk stands for the reconfiguration, register-unit
  // and application clocks, which are one clock here
  input wire logic ref_clk,
  input wire logic reset,
  // link to the fabric logic
  prc_if.dev lnk,
  // user side
  input wire logic local_pll_lock,
  output logic seq_done
);
  localparam int AW = prc_pkg::ADDR_W;
  localparam int DW = prc_pkg::DATA_W;
  localparam int RCW = $clog2(RST_SEQ_CYCLES + 1);
  localparam int LCW = $clog2(ACK_LAT + 1);
  localparam int PCW = $clog2(PHY_DIV + 1);
  localparam logic [RCW-1:0] RST_LAST = RCW'(RST_SEQ_CYCLES - 1);
  localparam logic [LCW-1:0] LAT_LAST = LCW'(ACK_LAT - 1);
  localparam logic [PCW-1:0] PHY_LAST = PCW'(PHY_DIV - 1);

  // reset sequence state
  prc_pkg::prc_rs_e rs_r;
  prc_pkg::prc_rs_e rs_nxt;
  logic [RCW-1:0] rs_cnt_r;
  logic [RCW-1:0] rs_cnt_nxt;
  logic done_r;
  logic done_nxt;
  logic intf_rdy_r;
  logic intf_rdy_nxt;
  logic lock_src;

  // transaction state
  prc_pkg::prc_xs_e xs_r;
  prc_pkg::prc_xs_e xs_nxt;
  logic [LCW-1:0] lat_cnt_r;
  logic [LCW-1:0] lat_cnt_nxt;
  logic [AW-1:0] addr_r;
  logic [AW-1:0] addr_nxt;
  logic wsel_r;
  logic wsel_nxt;
  logic [DW-1:0] wword_r;
  logic [DW-1:0] wword_nxt;
  logic ack_r;
  logic ack_nxt;
  logic [DW-1:0] rdata_r;
  logic [DW-1:0] rdata_nxt;
  logic finish;
  logic wr_en;

  // configuration words
  logic [DW-1:0] mem_r [prc_pkg::CFG_DEPTH];
  logic [DW-1:0] mem_nxt [prc_pkg::CFG_DEPTH];

  // shared phy clock divider
  logic [PCW-1:0] phy_cnt_r;
  logic [PCW-1:0] phy_cnt_nxt;
  logic phy_clk_r;
  logic phy_clk_nxt;

  // lock source: the combined lock when several interfaces share the pll
  assign lock_src = MULTI_INTF_EN ? lnk.multi_intf_lock_in : local_pll_lock;

  always_comb begin
    rs_nxt = rs_r;
    rs_cnt_nxt = rs_cnt_r;
    unique case (rs_r)
      prc_pkg::PRC_RS_WAIT_LOCK: begin
        if (lock_src) begin
          rs_nxt = prc_pkg::PRC_RS_COUNT;
          rs_cnt_nxt = '0;
        end
      end
      prc_pkg::PRC_RS_COUNT: begin
        if (rs_cnt_r == RST_LAST) begin
          rs_nxt = prc_pkg::PRC_RS_DONE;
        end else begin
          rs_cnt_nxt = rs_cnt_r + RCW'(1);
        end
      end
      prc_pkg::PRC_RS_DONE: begin
        rs_nxt = prc_pkg::PRC_RS_DONE;
      end
      default: begin
        rs_nxt = prc_pkg::PRC_RS_WAIT_LOCK;
      end
    endcase
    // done stays up once reached; a later loss of lock needs a reset
    done_nxt = (rs_nxt == prc_pkg::PRC_RS_DONE); // see [R10]
    intf_rdy_nxt = MULTI_INTF_EN && (rs_nxt == prc_pkg::PRC_RS_DONE); // see [R6]
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rs_r <= prc_pkg::PRC_RS_WAIT_LOCK;
      rs_cnt_r <= '0;
      done_r <= 1'b0;
      intf_rdy_r <= 1'b0;
    end else begin
      rs_r <= rs_nxt;
      rs_cnt_r <= rs_cnt_nxt;
      done_r <= done_nxt;
      intf_rdy_r <= intf_rdy_nxt;
    end
  end

  assign finish = (xs_r == prc_pkg::PRC_XS_BUSY) && (lat_cnt_r == LAT_LAST);
  assign wr_en = finish && wsel_r; // see [R3]

  // a strobe while busy or before the reset sequence is ignored, so a
  // fabric that breaks the one-at-a-time order loses that request
  always_comb begin
    xs_nxt = xs_r;
    lat_cnt_nxt = lat_cnt_r;
    addr_nxt = addr_r;
    wsel_nxt = wsel_r;
    wword_nxt = wword_r;
    ack_nxt = 1'b0; // see [R12]
    rdata_nxt = '0; // see [R5]
    unique case (xs_r)
      prc_pkg::PRC_XS_IDLE: begin
        if (lnk.cfg_strobe && done_r) begin // see [R2] [R10] [R11]
          xs_nxt = prc_pkg::PRC_XS_BUSY;
          lat_cnt_nxt = '0;
          addr_nxt = lnk.cfg_addr; // see [R1]
          wsel_nxt = lnk.cfg_write_sel; // see [R3]
          wword_nxt = lnk.reconfig_write_word; // see [R4]
        end
      end
      prc_pkg::PRC_XS_BUSY: begin
        if (finish) begin
          xs_nxt = prc_pkg::PRC_XS_IDLE;
          ack_nxt = 1'b1; // see [R5] [R12]
          if (!wsel_r) begin
            rdata_nxt = mem_r[addr_r]; // see [R3] [R5]
          end
        end else begin
          lat_cnt_nxt = lat_cnt_r + LCW'(1);
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      xs_r <= prc_pkg::PRC_XS_IDLE;
      lat_cnt_r <= '0;
      addr_r <= '0;
      wsel_r <= 1'b0;
      wword_r <= '0;
      ack_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      xs_r <= xs_nxt;
      lat_cnt_r <= lat_cnt_nxt;
      addr_r <= addr_nxt;
      wsel_r <= wsel_nxt;
      wword_r <= wword_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // configuration word store, one flop group per entry
  for (genvar i = 0; i < prc_pkg::CFG_DEPTH; i++) begin : g_word
    always_comb begin
      mem_nxt[i] = mem_r[i];
      if (wr_en && (addr_r == AW'(i))) begin
        mem_nxt[i] = wword_r; // see [R3] [R4]
      end
    end

    always_ff @(posedge ref_clk) begin
      if (reset) begin
        mem_r[i] <= prc_pkg::CFG_WORD_RST;
      end else begin
        mem_r[i] <= mem_nxt[i];
      end
    end
  end

  // stand-in for the second pll's phy clock; a real part takes it from the pll
  always_comb begin
    phy_cnt_nxt = phy_cnt_r;
    phy_clk_nxt = phy_clk_r;
    if (IS_MASTER) begin
      if (phy_cnt_r == PHY_LAST) begin
        phy_cnt_nxt = '0;
        phy_clk_nxt = !phy_clk_r; // see [R9]
      end else begin
        phy_cnt_nxt = phy_cnt_r + PCW'(1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phy_cnt_r <= '0;
      phy_clk_r <= 1'b0;
    end else begin
      phy_cnt_r <= phy_cnt_nxt;
      phy_clk_r <= phy_clk_nxt;
    end
  end

  // all fabric-side outputs come from ref_clk flops
  assign lnk.cfg_ack = ack_r; // see [R8]
  assign lnk.cfg_read_word = rdata_r;
  assign lnk.rst_seq_done = done_r;
  assign lnk.intf_rdy = intf_rdy_r;
  assign lnk.shared_second_phy_clock_out = phy_clk_r;
  assign seq_done = done_r;
endmodule // prc_device_end
`default_nettype wire

/* File: hw/prc_host_end.sv */
`timescale 1ns/1ps
`default_nettype none
module prc_host_end #(
  parameter int unsigned N_INTF = prc_pkg::N_INTF
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // link to the device
  prc_if.host lnk,
  // user request
  input wire logic req,
  input wire logic req_write,
  input wire logic [prc_pkg::ADDR_W-1:0] req_addr,
  input wire logic [prc_pkg::DATA_W-1:0] req_word,
  // lock indications of every interface
  input wire logic [N_INTF-1:0] lock_vec,
  // user answer
  output logic ready,
  output logic done,
  output logic [prc_pkg::DATA_W-1:0] rd_word,
  output logic link_up
);
  prc_pkg::prc_hs_e hs_r;
  prc_pkg::prc_hs_e hs_nxt;
  logic strobe_r;
  logic strobe_nxt;
  logic wsel_r;
  logic wsel_nxt;
  logic [prc_pkg::ADDR_W-1:0] addr_r;
  logic [prc_pkg::ADDR_W-1:0] addr_nxt;
  logic [prc_pkg::DATA_W-1:0] wword_r;
  logic [prc_pkg::DATA_W-1:0] wword_nxt;
  logic ready_r;
  logic ready_nxt;
  logic done_r;
  logic done_nxt;
  logic [prc_pkg::DATA_W-1:0] rd_r;
  logic [prc_pkg::DATA_W-1:0] rd_nxt;
  logic lock_r;
  logic lock_nxt;
  logic up_r;
  logic up_nxt;

  always_comb begin
    hs_nxt = hs_r;
    strobe_nxt = 1'b0; // see [R11]
    wsel_nxt = wsel_r;
    addr_nxt = addr_r;
    wword_nxt = wword_r;
    ready_nxt = ready_r;
    done_nxt = 1'b0;
    rd_nxt = rd_r;
    lock_nxt = &lock_vec; // see [R7]
    up_nxt = lnk.rst_seq_done && lnk.intf_rdy;
    unique case (hs_r)
      prc_pkg::PRC_HS_IDLE: begin
        ready_nxt = lnk.rst_seq_done; // see [R10]
        if (req && ready_r) begin
          hs_nxt = prc_pkg::PRC_HS_WAIT;
          strobe_nxt = 1'b1; // see [R2] [R11]
          wsel_nxt = req_write; // see [R3]
          addr_nxt = req_addr; // see [R1]
          wword_nxt = req_word; // see [R4]
          ready_nxt = 1'b0;
        end
      end
      prc_pkg::PRC_HS_WAIT: begin
        if (lnk.cfg_ack) begin // see [R5] [R11]
          hs_nxt = prc_pkg::PRC_HS_IDLE;
          done_nxt = 1'b1;
          ready_nxt = 1'b1;
          if (!wsel_r) begin
            rd_nxt = lnk.cfg_read_word; // see [R5]
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hs_r <= prc_pkg::PRC_HS_IDLE;
      strobe_r <= 1'b0;
      wsel_r <= 1'b0;
      addr_r <= '0;
      wword_r <= '0;
      ready_r <= 1'b0;
      done_r <= 1'b0;
      rd_r <= '0;
      lock_r <= 1'b0;
      up_r <= 1'b0;
    end else begin
      hs_r <= hs_nxt;
      strobe_r <= strobe_nxt;
      wsel_r <= wsel_nxt;
      addr_r <= addr_nxt;
      wword_r <= wword_nxt;
      ready_r <= ready_nxt;
      done_r <= done_nxt;
      rd_r <= rd_nxt;
      lock_r <= lock_nxt;
      up_r <= up_nxt;
    end
  end

  assign lnk.cfg_strobe = strobe_r;
  assign lnk.cfg_write_sel = wsel_r;
  assign lnk.cfg_addr = addr_r;
  assign lnk.reconfig_write_word = wword_r;
  assign lnk.multi_intf_lock_in = lock_r;
  assign ready = ready_r;
  assign done = done_r;
  assign rd_word = rd_r;
  assign link_up = up_r;
endmodule // prc_host_end
`default_nettype wire

/* File: testbench/prc_link_props.sv */
`timescale 1ns/1ps
`default_nettype none
module prc_link_props #(
  parameter int unsigned RST_SEQ_CYCLES = 20
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // link signals
  input wire logic cfg_strobe,
  input wire logic cfg_write_sel,
  input wire logic [prc_pkg::DATA_W-1:0] cfg_read_word,
  input wire logic cfg_ack,
  input wire logic rst_seq_done,
  input wire logic intf_rdy,
  input wire logic multi_intf_lock_in,
  input wire logic shared_second_phy_clock_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // the strobe is taken at the edge that samples it; ack is set two edges later
  // and so is first sampled three edges after the strobe
  a_ack_latency: assert property (cfg_strobe |-> ##1 !cfg_ack ##1 !cfg_ack ##1 cfg_ack)
    else $error("ack not three edges after strobe");
  a_ack_cause: assert property (cfg_ack |-> $past(cfg_strobe, 3))
    else $error("ack without strobe");
  a_ack_single: assert property (cfg_ack |=> !cfg_ack)
    else $error("ack longer than one cycle");
  a_word_idle_zero: assert property (!cfg_ack |-> cfg_read_word == 16'h0000)
    else $error("read word outside ack");
  a_write_ack_zero: assert property (cfg_ack && cfg_write_sel |-> cfg_read_word == 16'h0000)
    else $error("read word on write ack");
  a_strobe_pulse: assert property (cfg_strobe |=> !cfg_strobe)
    else $error("strobe longer than one cycle");
  a_strobe_gated: assert property (cfg_strobe |-> rst_seq_done)
    else $error("strobe before reset sequence");
  a_rdy_tracks_done: assert property (intf_rdy == rst_seq_done)
    else $error("interface ready differs");
  a_done_after_lock: assert property ($rose(rst_seq_done) |-> $past(multi_intf_lock_in, RST_SEQ_CYCLES))
    else $error("sequence done without lock");
  a_done_sticky: assert property (rst_seq_done |=> rst_seq_done)
    else $error("sequence done dropped");
  a_phy_period: assert property ($rose(shared_second_phy_clock_out) |=> shared_second_phy_clock_out ##1 !shared_second_phy_clock_out)
    else $error("phy clock period wrong");

  c_read_ack: cover property (cfg_ack && !cfg_write_sel);
  c_write_ack: cover property (cfg_ack && cfg_write_sel);
  c_seq_done: cover property ($rose(rst_seq_done));
endmodule // prc_link_props
`default_nettype wire

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic [6:0] req_addr = 7'h00;
  logic [15:0] req_word = 16'h0000;
  logic [1:0] lock_vec = 2'h1;
  logic ready, done, link_up, seq_done;
  logic [15:0] rd_word, r;
  int num_errors = 0;
  int comparisons = 0;
  int lat, n;
  logic phy_prev;
  logic [6:0] adr [3] = '{7'h00, 7'h7f, 7'h2a};
  logic [15:0] wrd [3] = '{16'ha5c3, 16'hffff, 16'h1234};

  always #2.5 ref_clk = ~ref_clk;

  prc_if lnk();
  prc_device_end u_prc_device_end (.ref_clk(ref_clk), .reset(reset), .lnk(lnk),
    .local_pll_lock(1'b0), .seq_done(seq_done));
  prc_host_end u_prc_host_end (.ref_clk(ref_clk), .reset(reset), .lnk(lnk), .req(req),
    .req_write(req_write), .req_addr(req_addr), .req_word(req_word), .lock_vec(lock_vec),
    .ready(ready), .done(done), .rd_word(rd_word), .link_up(link_up));
  prc_link_props u_props (.ref_clk(ref_clk), .reset(reset), .cfg_strobe(lnk.cfg_strobe),
    .cfg_write_sel(lnk.cfg_write_sel), .cfg_read_word(lnk.cfg_read_word),
    .cfg_ack(lnk.cfg_ack), .rst_seq_done(lnk.rst_seq_done), .intf_rdy(lnk.intf_rdy),
    .multi_intf_lock_in(lnk.multi_intf_lock_in),
    .shared_second_phy_clock_out(lnk.shared_second_phy_clock_out));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  // one user transfer; lat counts edges from take to done
  task automatic xfer(input logic wr, input logic [6:0] a, input logic [15:0] w);
    n = 0;
    while (ready !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    @(posedge ref_clk);
    req <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_word <= w;
    @(posedge ref_clk);
    req <= 1'b0;
    lat = 0;
    do begin
      @(posedge ref_clk);
      #1;
      lat++;
    end while (done !== 1'b1 && lat < 50);
    r = rd_word;
    chk("latency", 16'h0004, 16'(lat));
  endtask

  task automatic give_verdict();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #20000;
    num_errors++;
    give_verdict();
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (40) @(posedge ref_clk);
    #1;
    // one interface unlocked keeps the link down
    chk("done partial lock", 16'h0000, {15'h0, lnk.rst_seq_done});
    chk("up partial lock", 16'h0000, {15'h0, link_up});
    @(posedge ref_clk);
    lock_vec <= 2'h3;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (lnk.rst_seq_done !== 1'b1 && n < 100);
    chk("done delay", 16'(prc_pkg::RST_SEQ_CYC + 2), 16'(n));
    chk("intf ready", 16'h0001, {15'h0, lnk.intf_rdy});
    chk("seq done", 16'h0001, {15'h0, seq_done});
    // the shared phy clock toggles once every PHY_DIV_CYC edges
    n = 0;
    phy_prev = lnk.shared_second_phy_clock_out;
    repeat (16) begin
      @(posedge ref_clk);
      #1;
      if (lnk.shared_second_phy_clock_out !== phy_prev) n++;
      phy_prev = lnk.shared_second_phy_clock_out;
    end
    chk("phy toggles", 16'(16 / prc_pkg::PHY_DIV_CYC), 16'(n));
    chk("link up", 16'h0001, {15'h0, link_up});
    xfer(1'b0, 7'h7f, 16'h0000);
    chk("reset word", 16'h0000, r);
    for (int i = 0; i < 3; i++) xfer(1'b1, adr[i], wrd[i]);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b0, adr[i], 16'h0000);
      chk("read back", wrd[i], r);
    end
    xfer(1'b1, 7'h2a, 16'h0001);
    xfer(1'b0, 7'h2a, 16'hffff);
    chk("overwrite", 16'h0001, r);
    // a write after the read must leave the last read word in place
    xfer(1'b1, 7'h2a, 16'h5a5a);
    chk("write keeps rd", 16'h0001, rd_word);
    xfer(1'b0, 7'h2a, 16'h0000);
    chk("second write", 16'h5a5a, r);
    repeat (4) @(posedge ref_clk);
    give_verdict();
  end
endmodule // tb
`default_nettype wire
